// ==== core/lcmp_top.sv ====
/*
 * Linear-to-log compander with control, sample and code registers on a
 * plain strobe port. Assumes one-cycle strobes, never both at once, and
 * read data sampled in the cycle after the read strobe.
 */
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
module lcmp_top (
    input wire logic core_clk, // system clock, 100 MHz
    input wire logic rst, // synchronous reset, active high
    input wire logic [15:0] reg_addr, // register word address
    input wire logic [15:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [15:0] reg_rdata // read data, one cycle after strobe
);
    logic mode_q;
    logic mode_d;
    logic [15:0] sample_q;
    logic [15:0] sample_d;
    logic [7:0] code_q;
    logic [7:0] code_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic samp_seen_q;

    wire logic hit_ctrl = reg_addr == lcmp_pkg::ADDR_CONTROL;
    wire logic hit_samp = reg_addr == lcmp_pkg::ADDR_SAMPLE;
    wire logic hit_code = reg_addr == lcmp_pkg::ADDR_CODE;
    wire logic wr_ctrl = reg_wr && hit_ctrl;
    wire logic wr_samp = reg_wr && hit_samp;

    assign mode_d = wr_ctrl ? reg_wdata[lcmp_pkg::MODE_BIT] : mode_q;
    assign sample_d = wr_samp ? reg_wdata : sample_q;

    wire logic [7:0] a_code;
    wire logic [7:0] u_code;
    lcmp_alaw_enc u_alaw (
        .lin_s(sample_q[15:3]),
        .code(a_code)
    );
    lcmp_mulaw_enc u_mulaw (
        .lin_s(sample_q[15:2]),
        .code(u_code)
    );
    // code register follows the current mode and the stored sample one cycle later
    assign code_d = (mode_q == lcmp_pkg::MODE_MULAW) ? u_code : a_code;

    wire logic [15:0] ctrl_view = {15'h0000, mode_q};
    wire logic [15:0] code_view = {lcmp_pkg::CODE_ZERO_HI, code_q};
    // sample register is write-only; unmapped reads return zero
    assign rdata_d = !reg_rd ? 16'h0000 :
                     hit_ctrl ? ctrl_view :
                     hit_code ? code_view : 16'h0000;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            mode_q <= lcmp_pkg::CONTROL_RESET[lcmp_pkg::MODE_BIT];
            rdata_q <= 16'h0000;
            samp_seen_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            rdata_q <= rdata_d;
            samp_seen_q <= samp_seen_q || wr_samp;
        end
    end

    // no reset on datapath registers
    always_ff @(posedge core_clk) begin
        sample_q <= sample_d;
        code_q <= code_d;
    end

    assign reg_rdata = rdata_q;

    AST_CTRL_RESET: assert property (@(posedge core_clk)
        $past(rst) |-> mode_q == 1'b0) else $error("mode not zero after reset");
    AST_MODE_WRITE: assert property (@(posedge core_clk) disable iff (rst)
        wr_ctrl |=> mode_q == $past(reg_wdata[0])) else $error("mode write lost");
    AST_SAMPLE_WRITE: assert property (@(posedge core_clk) disable iff (rst)
        wr_samp |=> sample_q == $past(reg_wdata)) else $error("sample write lost");
    AST_CODE_HI_ZERO: assert property (@(posedge core_clk) disable iff (rst)
        $past(reg_rd && hit_code) |-> reg_rdata[15:8] == 8'h00)
        else $error("code upper byte not zero");
    AST_CODE_MODE: assert property (@(posedge core_clk) disable iff (rst)
        samp_seen_q && !wr_samp && !wr_ctrl ##1 !wr_samp && !wr_ctrl |=>
        code_q == (mode_q ? u_code : a_code)) else $error("code not per mode");
    AST_MU_LOW_IGNORED: assert property (@(posedge core_clk) disable iff (rst)
        wr_samp ##1 wr_samp && reg_wdata[15:2] == $past(reg_wdata[15:2]) && mode_q
        ##0 !wr_ctrl |=> u_code == $past(u_code)) else $error("mu-law used low bits");
    AST_A_LOW_IGNORED: assert property (@(posedge core_clk) disable iff (rst)
        wr_samp ##1 wr_samp && reg_wdata[15:3] == $past(reg_wdata[15:3])
        |=> a_code == $past(a_code)) else $error("A-law used low bits");
    AST_READ_NEXT: assert property (@(posedge core_clk) disable iff (rst)
        wr_samp ##1 !wr_samp && !wr_ctrl ##1 reg_rd && hit_code |=>
        reg_rdata[7:0] == (mode_q ? u_code : a_code)) else $error("stale code read");
    AST_ALAW_ZERO: assert property (@(posedge core_clk) disable iff (rst)
        sample_q[15:3] == 13'h0000 |-> a_code == 8'hd5) else $error("A-law zero code");
    AST_MULAW_ZERO: assert property (@(posedge core_clk) disable iff (rst)
        sample_q[15:2] == 14'h0000 |-> u_code == 8'hff) else $error("mu-law zero code");
endmodule // lcmp_top

// ==== core/lcmp_pkg.sv ====
/*
 * Constants for the linear-to-log compander: register addresses, field
 * positions, reset values and the mode encoding.
 * Assumes a 16-bit register port with word addresses as printed.
 */
package lcmp_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam logic [15:0] ADDR_CONTROL = 16'hd020;
    localparam logic [15:0] ADDR_SAMPLE = 16'hd021;
    localparam logic [15:0] ADDR_CODE = 16'hd022;
    localparam int MODE_BIT = 0;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic MODE_ALAW = 1'h0;
    localparam logic MODE_MULAW = 1'h1;
    localparam logic [7:0] ALAW_XOR = 8'h55;
    localparam logic [13:0] MULAW_BIAS = 14'h0021;
    localparam logic [7:0] CODE_ZERO_HI = 8'h00;
endpackage : lcmp_pkg

// ==== core/lcmp_alaw_enc.sv ====
/*
 * A-law encoder: 13-bit signed sample to 8-bit code.
 * Assumes the caller presents the 13 upper bits of the linear sample.
 */
`timescale 1ns/1ps
module lcmp_alaw_enc (
    input wire logic [12:0] lin_s, // upper 13 bits, two's complement
    output logic [7:0] code // compressed code
);
    wire logic sign_neg = lin_s[12];
    wire logic [11:0] mag = sign_neg ? 12'(~lin_s[11:0]) : lin_s[11:0];
    logic [2:0] seg;
    logic [3:0] mant;
    // segment from leading one position, mantissa from the next four bits
    always_comb begin
        seg = 3'h0;
        mant = mag[4:1];
        if (mag[11]) begin
            seg = 3'h7;
            mant = mag[10:7];
        end else if (mag[10]) begin
            seg = 3'h6;
            mant = mag[9:6];
        end else if (mag[9]) begin
            seg = 3'h5;
            mant = mag[8:5];
        end else if (mag[8]) begin
            seg = 3'h4;
            mant = mag[7:4];
        end else if (mag[7]) begin
            seg = 3'h3;
            mant = mag[6:3];
        end else if (mag[6]) begin
            seg = 3'h2;
            mant = mag[5:2];
        end else if (mag[5]) begin
            seg = 3'h1;
            mant = mag[4:1];
        end
    end
    // positive sign bit set, then even-bit inversion
    assign code = {~sign_neg, seg, mant} ^ lcmp_pkg::ALAW_XOR;
endmodule // lcmp_alaw_enc

// ==== core/lcmp_mulaw_enc.sv ====
/*
 * Mu-law encoder: 14-bit signed sample to 8-bit code.
 * Assumes the caller presents the 14 upper bits of the linear sample.
 */
`timescale 1ns/1ps
module lcmp_mulaw_enc (
    input wire logic [13:0] lin_s, // upper 14 bits, two's complement
    output logic [7:0] code // compressed code
);
    wire logic sign_neg = lin_s[13];
    wire logic [12:0] mag0 = sign_neg ? 13'(~lin_s[12:0]) : lin_s[12:0];
    // clip so bias cannot overflow
    wire logic [12:0] magc = (mag0 > 13'h1fde) ? 13'h1fde : mag0;
    wire logic [13:0] mag = {1'b0, magc} + lcmp_pkg::MULAW_BIAS;
    logic [2:0] seg;
    logic [3:0] mant;
    always_comb begin
        seg = 3'h0;
        mant = mag[4:1];
        if (mag[12]) begin
            seg = 3'h7;
            mant = mag[11:8];
        end else if (mag[11]) begin
            seg = 3'h6;
            mant = mag[10:7];
        end else if (mag[10]) begin
            seg = 3'h5;
            mant = mag[9:6];
        end else if (mag[9]) begin
            seg = 3'h4;
            mant = mag[8:5];
        end else if (mag[8]) begin
            seg = 3'h3;
            mant = mag[7:4];
        end else if (mag[7]) begin
            seg = 3'h2;
            mant = mag[6:3];
        end else if (mag[6]) begin
            seg = 3'h1;
            mant = mag[5:2];
        end
    end
    // whole code complemented
    assign code = ~{sign_neg, seg, mant};
endmodule // lcmp_mulaw_enc

// ==== dv/linear_to_log_compander_bench.sv ====
/*
 * Self-checking bench for the compander: control, sample and code registers.
 * Assumes lcmp_top on a one-cycle strobe port, read data one cycle later.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module linear_to_log_compander_bench;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    int err_count = 0;
    int checks_done = 0;
    always #5 core_clk = ~core_clk;
    lcmp_top i_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    // reference coders, upper sample bits only
    function automatic logic [7:0] alaw_ref(input logic [15:0] x);
        logic [11:0] m;
        logic [2:0] seg;
        m = x[15] ? ~x[14:3] : x[14:3];
        seg = 3'h0;
        for (int i = 5; i < 12; i++) if (m[i]) seg = 3'(i - 4);
        return {~x[15], seg, (seg == 3'h0) ? m[4:1] : 4'(m >> seg)} ^ lcmp_pkg::ALAW_XOR;
    endfunction
    function automatic logic [7:0] mulaw_ref(input logic [15:0] x);
        logic [13:0] b;
        logic [2:0] seg;
        b = {1'b0, (x[15] ? ~x[14:2] : x[14:2])} + lcmp_pkg::MULAW_BIAS;
        if (b[13]) b = 14'h1fff;
        seg = 3'h0;
        for (int i = 6; i < 13; i++) if (b[i]) seg = 3'(i - 5);
        return ~{x[15], seg, 4'(b >> (4'(seg) + 4'h1))};
    endfunction
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
    endtask
    task automatic idle();
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        reg_rd <= 1'b1;
        reg_wr <= 1'b0;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
        d = reg_rdata;
    endtask
    task automatic t_reset();
        logic [15:0] v;
        rd(lcmp_pkg::ADDR_CONTROL, v);
        `CHK(v, lcmp_pkg::CONTROL_RESET)
        wr(lcmp_pkg::ADDR_SAMPLE, 16'h0000);
        idle();
        rd(lcmp_pkg::ADDR_CODE, v);
        `CHK(v, 16'h00d5)
        wr(lcmp_pkg::ADDR_CONTROL, 16'hfffe);
        rd(lcmp_pkg::ADDR_CONTROL, v);
        `CHK(v, 16'h0000)
        wr(lcmp_pkg::ADDR_CONTROL, 16'hffff);
        rd(lcmp_pkg::ADDR_CONTROL, v);
        `CHK(v, 16'h0001)
        $display("t_reset done");
    endtask
    task automatic t_codes();
        logic [15:0] tbl [10] = '{16'h0000, 16'h0007, 16'h0003, 16'h0004, 16'hffff,
            16'h7fff, 16'h8000, 16'h1234, 16'hfedc, 16'h0100};
        logic [15:0] v;
        logic [15:0] e;
        for (int m = 0; m < 2; m++) begin
            wr(lcmp_pkg::ADDR_CONTROL, 16'(m));
            foreach (tbl[i]) begin
                wr(lcmp_pkg::ADDR_SAMPLE, tbl[i]);
                idle();
                rd(lcmp_pkg::ADDR_CODE, v);
                e = {8'h00, (m == 1) ? mulaw_ref(tbl[i]) : alaw_ref(tbl[i])};
                `CHK(v, e)
            end
        end
        $display("t_codes done");
    endtask
    task automatic t_map();
        logic [15:0] v;
        wr(lcmp_pkg::ADDR_CONTROL, 16'h0000);
        wr(lcmp_pkg::ADDR_SAMPLE, 16'h4321);
        wr(lcmp_pkg::ADDR_CODE, 16'h00aa);
        idle();
        rd(lcmp_pkg::ADDR_CODE, v);
        `CHK(v, {8'h00, alaw_ref(16'h4321)})
        rd(lcmp_pkg::ADDR_SAMPLE, v);
        `CHK(v, 16'h0000)
        rd(16'hd023, v);
        `CHK(v, 16'h0000)
        $display("t_map done");
    endtask
    task automatic t_timing();
        logic [15:0] v;
        wr(lcmp_pkg::ADDR_SAMPLE, 16'h1234);
        idle();
        idle();
        wr(lcmp_pkg::ADDR_SAMPLE, 16'h8000);
        rd(lcmp_pkg::ADDR_CODE, v);
        `CHK(v, {8'h00, alaw_ref(16'h1234)})
        rd(lcmp_pkg::ADDR_CODE, v);
        `CHK(v, {8'h00, alaw_ref(16'h8000)})
        $display("t_timing done");
    endtask
    // back-to-back writes differing only in ignored low bits
    task automatic t_lowbits();
        logic [15:0] v;
        wr(lcmp_pkg::ADDR_CONTROL, 16'h0001);
        wr(lcmp_pkg::ADDR_SAMPLE, 16'h1230);
        wr(lcmp_pkg::ADDR_SAMPLE, 16'h1233);
        idle();
        rd(lcmp_pkg::ADDR_CODE, v);
        `CHK(v, {8'h00, mulaw_ref(16'h1230)})
        wr(lcmp_pkg::ADDR_CONTROL, 16'h0000);
        wr(lcmp_pkg::ADDR_SAMPLE, 16'h1230);
        wr(lcmp_pkg::ADDR_SAMPLE, 16'h1237);
        idle();
        rd(lcmp_pkg::ADDR_CODE, v);
        `CHK(v, {8'h00, alaw_ref(16'h1230)})
        $display("t_lowbits done");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_codes();
        t_map();
        t_timing();
        t_lowbits();
        tally_and_finish();
    end
    initial begin
        repeat (2000) @(posedge core_clk);
        err_count++;
        tally_and_finish();
    end
endmodule // linear_to_log_compander_bench
